// >>> lec_ctrl.sv
`timescale 1ns/1ps
module lec_ctrl (
    // Clock and reset.
    input  wire logic                          i_clk_sys,
    input  wire logic                          i_rstn,
    // APB slave.
    input  wire logic                          i_psel,
    input  wire logic                          i_penable,
    input  wire logic                          i_pwrite,
    input  wire logic [lec_pkg::ADDR_W-1:0]    i_paddr,
    input  wire logic [lec_pkg::DATA_W-1:0]    i_pwdata,
    input  wire logic [3:0]                    i_pstrb,
    output logic [lec_pkg::DATA_W-1:0]         o_prdata,
    output logic                               o_pready,
    output logic                               o_pslverr,
    // Lookup datapath: frame classification inputs.
    input  wire logic                          i_vid_invalid,
    input  wire logic                          i_unknown_vid_fwd_en,
    input  wire logic [47:0]                   i_dest_addr,
    input  wire logic                          i_entry_update,
    input  wire logic [7:0]                    i_age_period,
    input  wire logic                          i_age_tick,
    // Lookup datapath: decisions.
    output lec_pkg::lec_ctrl_s                 o_ctrl,
    output lec_pkg::lec_vid_act_s              o_vid_act,
    output logic [lec_pkg::IDX_W-1:0]          o_table_index,
    output logic [2:0]                         o_entry_age_count,
    output logic                               o_entry_age_valid,
    output logic [10:0]                        o_aging_ticks,
    output logic                               o_rsvd_mc_lookup
);
    import lec_pkg::*;

    // Control register and staged datapath outputs.
    logic [CTRL_W-1:0]   ctrl_q;
    logic [CTRL_W-1:0]   ctrl_d;
    logic [DATA_W-1:0]   prdata_q;
    logic [DATA_W-1:0]   prdata_d;
    logic                pslverr_q;
    lec_vid_act_s        vid_act_q;
    lec_vid_act_s        vid_act_d;
    logic [2:0]          age_stamp_q;
    logic                age_valid_q;
    logic [IDX_W-1:0]    index_q;
    logic [10:0]         aging_q;
    logic [IDX_W-1:0]    index_w;

    // Access phase decode; the slave answers in the first access cycle.
    wire logic hit_w     = (i_paddr == LEC_CTRL0_ADDR);
    wire logic access_w  = i_psel & i_penable;
    wire logic wr_w      = access_w & i_pwrite & hit_w & i_pstrb[0];
    wire logic rd_w      = access_w & ~i_pwrite & hit_w;
    wire logic miss_w    = access_w & ~hit_w;

    // Write lane 0 only updates the register; other lanes hold nothing.
    assign ctrl_d   = wr_w ? i_pwdata[CTRL_W-1:0] : ctrl_q;
    // Read data shows the stored byte with the upper bits zero.
    assign prdata_d = rd_w ? {{(DATA_W-CTRL_W){1'b0}}, ctrl_q} : '0;

    // Field view of the register for the datapath.
    assign o_ctrl.vlan_en      = ctrl_q[VLAN_EN_BIT];
    assign o_ctrl.drop_invalid = ctrl_q[DROP_INV_BIT];
    assign o_ctrl.age_count    = ctrl_q[AGE_MSB:AGE_LSB];
    assign o_ctrl.rsvd_mc_en   = ctrl_q[RSVD_MC_BIT];
    assign o_ctrl.hash_select  = lec_hash_e'(ctrl_q[HASH_MSB:HASH_LSB]);

    // Invalid VID disposition; unknown-VID forwarding takes precedence.
    // Without VLAN mode no VID is judged, so nothing is diverted.
    wire logic judge_w = ctrl_q[VLAN_EN_BIT] & i_vid_invalid;
    assign vid_act_d.to_unknown = judge_w & i_unknown_vid_fwd_en;
    assign vid_act_d.drop       = judge_w & ~i_unknown_vid_fwd_en & ctrl_q[DROP_INV_BIT];
    assign vid_act_d.to_host    = judge_w & ~i_unknown_vid_fwd_en & ~ctrl_q[DROP_INV_BIT];

    // Reserved multicast lookup gate is a plain level from the register.
    assign o_rsvd_mc_lookup = ctrl_q[RSVD_MC_BIT];

    // Table index computed by the selected mapping.
    lec_index u_index (
        .i_hash_select (lec_hash_e'(ctrl_q[HASH_MSB:HASH_LSB])),
        .i_dest_addr   (i_dest_addr),
        .o_index       (index_w)
    );

    // Register bank and bus answer; pready is immediate, so no wait states.
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            ctrl_q    <= LEC_CTRL0_RESET;
            prdata_q  <= '0;
            pslverr_q <= 1'b0;
        end else begin
            ctrl_q    <= ctrl_d;
            prdata_q  <= prdata_d;
            pslverr_q <= miss_w;
        end
    end

    // Datapath staging; age stamping samples the live age count on update.
    always_ff @(posedge i_clk_sys or negedge i_rstn) begin
        if (!i_rstn) begin
            vid_act_q   <= '0;
            age_stamp_q <= '0;
            age_valid_q <= 1'b0;
            index_q     <= '0;
            aging_q     <= '0;
        end else begin
            vid_act_q   <= vid_act_d;
            index_q     <= index_w;
            age_valid_q <= i_entry_update;
            if (i_entry_update) begin
                age_stamp_q <= ctrl_q[AGE_MSB:AGE_LSB];
            end
            // Aging time in age ticks is count times period; the period tick source lives outside.
            aging_q     <= 11'(ctrl_q[AGE_MSB:AGE_LSB]) * 11'(i_age_period);
        end
    end

    // Read data is driven combinationally in the access cycle so pready can be high at once.
    assign o_prdata          = rd_w ? prdata_d : prdata_q;
    assign o_pready          = 1'b1;
    assign o_pslverr         = miss_w;
    assign o_vid_act         = vid_act_q;
    assign o_table_index     = index_q;
    assign o_entry_age_count = age_stamp_q;
    assign o_entry_age_valid = age_valid_q;
    assign o_aging_ticks     = aging_q;

    // The age tick is only carried for the aging engine outside and has no effect here.
    wire logic unused_w = i_age_tick ^ pslverr_q;

endmodule : lec_ctrl

// >>> lec_pkg.sv
package lec_pkg;

    // Bus and register geometry.
    localparam int unsigned ADDR_W            = 12;
    localparam int unsigned DATA_W            = 32;
    localparam int unsigned CTRL_W            = 8;

    // Printed offset 0x0310 is word aligned, so it is the byte address.
    localparam logic [11:0] LEC_CTRL0_ADDR    = 12'h310;

    // Field positions inside the control register.
    localparam int unsigned VLAN_EN_BIT       = 7;
    localparam int unsigned DROP_INV_BIT      = 6;
    localparam int unsigned AGE_MSB           = 5;
    localparam int unsigned AGE_LSB           = 3;
    localparam int unsigned RSVD_MC_BIT       = 2;
    localparam int unsigned HASH_MSB          = 1;
    localparam int unsigned HASH_LSB          = 0;

    // Reset value: vlan off, drop invalid on, age 100b, reserved mc off, crc hash.
    localparam logic [7:0]  LEC_CTRL0_RESET   = 8'h61;

    // Dynamic table index width and hash encodings.
    localparam int unsigned IDX_W             = 10;

    // Hash selection codes.
    typedef enum logic [1:0] {
        LEC_HASH_DIRECT0 = 2'h0,
        LEC_HASH_CRC     = 2'h1,
        LEC_HASH_XOR     = 2'h2,
        LEC_HASH_DIRECT3 = 2'h3
    } lec_hash_e;

    // Decoded control settings handed to the lookup datapath.
    typedef struct packed {
        logic       vlan_en;
        logic       drop_invalid;
        logic [2:0] age_count;
        logic       rsvd_mc_en;
        lec_hash_e  hash_select;
    } lec_ctrl_s;

    // Frame disposition for an invalid VLAN ID.
    typedef struct packed {
        logic drop;
        logic to_host;
        logic to_unknown;
    } lec_vid_act_s;

endpackage : lec_pkg

// >>> lec_index.sv
`timescale 1ns/1ps
// Maps a destination address to a dynamic lookup table index.
module lec_index (
    // Selection.
    input  wire lec_pkg::lec_hash_e        i_hash_select,
    // Address in.
    input  wire logic [47:0]               i_dest_addr,
    // Index out.
    output logic [lec_pkg::IDX_W-1:0]      o_index
);
    import lec_pkg::*;

    // Folding xor of the 48-bit address into ten bits.
    function automatic logic [IDX_W-1:0] fold_xor(input logic [47:0] a);
        logic [IDX_W-1:0] r;
        r = '0;
        for (int i = 0; i < 48; i++) begin
            r[i % IDX_W] = r[i % IDX_W] ^ a[i];
        end
        return r;
    endfunction : fold_xor

    // Serial crc over the address with a ten bit polynomial; plain choice of taps.
    function automatic logic [IDX_W-1:0] crc10(input logic [47:0] a);
        logic [IDX_W-1:0] c;
        logic             fb;
        c = '1;
        for (int i = 47; i >= 0; i--) begin
            fb = c[IDX_W-1] ^ a[i];
            c  = {c[IDX_W-2:0], 1'b0};
            if (fb) begin
                c = c ^ 10'h233;
            end
        end
        return c;
    endfunction : crc10

    wire logic [IDX_W-1:0] direct_idx = i_dest_addr[IDX_W-1:0];
    wire logic [IDX_W-1:0] crc_idx    = crc10(i_dest_addr);
    wire logic [IDX_W-1:0] xor_idx    = fold_xor(i_dest_addr);

    // Codes 00 and 11 both map directly on the low address bits.
    assign o_index = (i_hash_select == LEC_HASH_CRC) ? crc_idx :
                     (i_hash_select == LEC_HASH_XOR) ? xor_idx :
                     direct_idx;

endmodule : lec_index

// >>> lec_ctrl_properties.sv
`timescale 1ns/1ps
// Watches the register bus and the lookup decisions from the top ports only.
module lec_ctrl_properties
    import lec_pkg::*;
(
    // Clock, reset and bus.
    input wire logic               i_clk_sys,
    input wire logic               i_rstn,
    input wire logic               i_psel,
    input wire logic               i_penable,
    input wire logic               i_pwrite,
    input wire logic [11:0]        i_paddr,
    input wire logic [31:0]        i_pwdata,
    input wire logic [3:0]         i_pstrb,
    input wire logic [31:0]        o_prdata,
    input wire logic               o_pslverr,
    // Datapath.
    input wire logic               i_vid_invalid,
    input wire logic               i_unknown_vid_fwd_en,
    input wire logic [47:0]        i_dest_addr,
    input wire logic               i_entry_update,
    input wire logic [7:0]         i_age_period,
    input wire lec_pkg::lec_ctrl_s    o_ctrl,
    input wire lec_pkg::lec_vid_act_s o_vid_act,
    input wire logic [9:0]         o_table_index,
    input wire logic [2:0]         o_entry_age_count,
    input wire logic               o_entry_age_valid,
    input wire logic [10:0]        o_aging_ticks
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rstn);
    // An access phase; pready is tied high, so every one completes.
    wire acc = i_psel && i_penable;
    wire hit = acc && i_paddr == LEC_CTRL0_ADDR;
    property p_rd; hit && !i_pwrite |-> o_prdata == {24'h0, o_ctrl}; endproperty
    a_rd: assert property (p_rd) else $error("read data differs from register");
    property p_wr; hit && i_pwrite && i_pstrb[0] |=> {24'h0, o_ctrl} == ($past(i_pwdata) & 32'hff); endproperty
    a_wr: assert property (p_wr) else $error("write not stored");
    property p_err; acc |-> o_pslverr == (i_paddr != LEC_CTRL0_ADDR); endproperty
    a_err: assert property (p_err) else $error("slave error wrong");
    property p_off; !o_ctrl.vlan_en |=> o_vid_act == 3'h0; endproperty
    a_off: assert property (p_off) else $error("action while vlan off");
    property p_vid; o_ctrl.vlan_en && i_vid_invalid && !i_unknown_vid_fwd_en
        |=> o_vid_act == {$past(o_ctrl.drop_invalid), !$past(o_ctrl.drop_invalid), 1'b0}; endproperty
    a_vid: assert property (p_vid) else $error("invalid vid action wrong");
    property p_unk; o_ctrl.vlan_en && i_vid_invalid && i_unknown_vid_fwd_en |=> o_vid_act == 3'h1; endproperty
    a_unk: assert property (p_unk) else $error("unknown vid not overriding");
    property p_age; i_entry_update |=> o_entry_age_valid && o_entry_age_count == $past(o_ctrl.age_count); endproperty
    a_age: assert property (p_age) else $error("age count not stamped");
    property p_tick; $past(i_rstn) |-> o_aging_ticks == $past(o_ctrl.age_count) * $past(i_age_period); endproperty
    a_tick: assert property (p_tick) else $error("aging time wrong");
    property p_idx; o_ctrl.hash_select inside {2'h0, 2'h3} |=> o_table_index == $past(i_dest_addr[9:0]); endproperty
    a_idx: assert property (p_idx) else $error("direct index wrong");
    c_wr: cover property (hit && i_pwrite);
    c_drop: cover property (o_vid_act.drop);
    c_upd: cover property (i_entry_update);
endmodule : lec_ctrl_properties

bind lec_ctrl lec_ctrl_properties u_props (.i_clk_sys, .i_rstn, .i_psel, .i_penable, .i_pwrite, .i_paddr,
    .i_pwdata, .i_pstrb, .o_prdata, .o_pslverr, .i_vid_invalid, .i_unknown_vid_fwd_en, .i_dest_addr,
    .i_entry_update, .i_age_period, .o_ctrl, .o_vid_act, .o_table_index, .o_entry_age_count,
    .o_entry_age_valid, .o_aging_ticks);

// >>> testbench.sv
`timescale 1ns/1ps
module testbench;
    import lec_pkg::*;
    // Bench signals carry the design's port names so the instance connects by name.
    logic i_clk_sys = 1'b0, i_rstn = 1'b0, i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0, err;
    logic i_vid_invalid = 1'b0, i_unknown_vid_fwd_en = 1'b0, i_entry_update = 1'b0, i_age_tick = 1'b0;
    logic [11:0] i_paddr = 12'h0;
    logic [31:0] i_pwdata = 32'h0, o_prdata, rd;
    logic [3:0]  i_pstrb = 4'h0;
    logic [47:0] i_dest_addr = 48'h1234_5678_9abc;
    logic [7:0]  i_age_period = 8'hc8;
    logic [9:0]  o_table_index, e, c;
    logic [10:0] o_aging_ticks;
    logic [2:0]  o_entry_age_count;
    logic o_pready, o_pslverr, o_entry_age_valid, o_rsvd_mc_lookup;
    lec_ctrl_s    o_ctrl;
    lec_vid_act_s o_vid_act;
    int fails = 0, n_checks = 0, cyc = 0;
    lec_ctrl dut (.i_clk_sys, .i_rstn, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .i_pstrb,
        .o_prdata, .o_pready, .o_pslverr, .i_vid_invalid, .i_unknown_vid_fwd_en, .i_dest_addr,
        .i_entry_update, .i_age_period, .i_age_tick, .o_ctrl, .o_vid_act, .o_table_index,
        .o_entry_age_count, .o_entry_age_valid, .o_aging_ticks, .o_rsvd_mc_lookup);
    // A 100 ns clock; the cycle ceiling cuts a hung handshake short.
    always #50 i_clk_sys = ~i_clk_sys;
    always @(posedge i_clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            fails++;
            stop_test();
        end
    end
    // One APB transfer; an idle edge first keeps two transfers from driving psel in one step.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        @(posedge i_clk_sys);
        i_psel <= 1'b1;
        i_pwrite <= w;
        i_paddr <= a;
        i_pwdata <= d;
        i_pstrb <= s;
        @(posedge i_clk_sys);
        i_penable <= 1'b1;
        @(posedge i_clk_sys);
        while (o_pready !== 1'b1) @(posedge i_clk_sys);
        rd = o_prdata;
        err = o_pslverr;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
    endtask : apb
    // Registered decisions lag their inputs by one edge, so two edges let them land.
    task automatic settle;
        repeat (2) @(posedge i_clk_sys);
    endtask : settle
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic stop_test;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : stop_test
    initial begin
        repeat (12) @(posedge i_clk_sys);
        i_rstn <= 1'b1;
        apb(1'b0, 12'h310, 32'h0, 4'h0);
        chk(rd, 32'h61);
        // Software would fill the VLAN table before this first enabling write; none is modelled here.
        apb(1'b1, 12'h310, 32'hffff_ffa6, 4'hf);
        apb(1'b0, 12'h310, 32'h0, 4'h0);
        chk(rd, 32'ha6);
        chk(o_rsvd_mc_lookup, 32'h1);
        // A write without lane 0 enabled must leave the register alone.
        apb(1'b1, 12'h310, 32'h0, 4'he);
        apb(1'b0, 12'h310, 32'h0, 4'h0);
        chk(rd, 32'ha6);
        apb(1'b0, 12'h314, 32'h0, 4'h0);
        chk(rd, 32'h0);
        chk(err, 32'h1);
        i_vid_invalid <= 1'b1;
        apb(1'b1, 12'h310, 32'h41, 4'h1);
        settle();
        chk(o_vid_act, 32'h0);
        apb(1'b1, 12'h310, 32'hc1, 4'h1);
        settle();
        chk(o_vid_act, 32'h4);
        apb(1'b1, 12'h310, 32'h81, 4'h1);
        settle();
        chk(o_vid_act, 32'h2);
        i_unknown_vid_fwd_en <= 1'b1;
        settle();
        chk(o_vid_act, 32'h1);
        // Age count 5 with period 200 gives 1000 age ticks.
        apb(1'b1, 12'h310, 32'h28, 4'h1);
        i_entry_update <= 1'b1;
        @(posedge i_clk_sys);
        i_entry_update <= 1'b0;
        @(posedge i_clk_sys);
        chk({o_entry_age_valid, o_entry_age_count}, 32'hd);
        chk(o_aging_ticks, 32'h3e8);
        e = 10'h0;
        for (int i = 0; i < 48; i++) e[i % 10] ^= i_dest_addr[i];
        // Serial CRC reference: polynomial 0x233, all ones start, address fed from its top bit down.
        c = 10'h3ff;
        for (int i = 47; i >= 0; i--) c = {c[8:0], 1'b0} ^ ((c[9] ^ i_dest_addr[i]) ? 10'h233 : 10'h000);
        // Every hash code is selected and each mapping is held against its own reference.
        for (int h = 0; h < 4; h++) begin
            apb(1'b1, 12'h310, 32'(h), 4'h1);
            settle();
            if (h == 1) chk(o_table_index, c);
            else if (h == 2) chk(o_table_index, e);
            else chk(o_table_index, i_dest_addr[9:0]);
        end
        // A mid-run reset must bring every field back to its default value.
        i_rstn <= 1'b0;
        repeat (2) @(posedge i_clk_sys);
        i_rstn <= 1'b1;
        chk(o_ctrl, 32'h61);
        apb(1'b0, 12'h310, 32'h0, 4'h0);
        chk(rd, 32'h61);
        stop_test();
    end
endmodule : testbench
